// ==== env_sensor_measure_control_regs.sv ====
// Measurement control, rate setup and raw result registers of the sensor.
// Assumes a serial slave engine on i_clk presenting one-cycle read and write
// strobes, and a converter that pulses i_result_valid when results are ready.
//
// Functional notes
// [R1] New moisture oversampling applies only after the next measurement control write.
// [R2] Measurement control bits 7:5 hold thermal oversampling.
// [R3] Measurement control bits 4:2 hold barometric oversampling.
// [R4] Measurement control bits 1:0 hold the operating mode.
// [R5] Oversampling 000 skips and forces 0x80000 (0x8000 for moisture); 1..4 give 1-8; 5+ give 16.
// [R6] Mode 00 sleep, 01/10 one forced measurement, 11 continuous normal.
// [R7] Rate setup writes ignored in normal mode, accepted otherwise.
// [R8] Rate setup bits 7:5 choose the idle time between normal cycles.
// [R9] Rate setup bits 4:2 choose filter: off, 2, 4, 8, 16 beyond.
// [R10] Rate setup bit 0 set selects three-wire serial port.
// [R11] Barometric result split over 0xF7, 0xF8 and upper nibble of 0xF9.
// [R12] Thermal result split over 0xFA, 0xFB and upper nibble of 0xFC.
// [R13] Moisture result high byte at 0xFD, low byte at 0xFE.
// [R14] Unused setup bit 1 and low result nibbles read zero, ignore writes.
`timescale 1ns/1ns

module env_sensor_measure_control_regs #(
   parameter logic [7:0][env_meas_pkg::STANDBY_W-1:0] STANDBY_CYCLES = env_meas_pkg::STANDBY_CYCLES_DEF
) (
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_rd,
   output logic      [7:0]  o_reg_rdata,
   input  wire logic        i_result_valid,
   input  wire logic [19:0] i_raw_baro_value,
   input  wire logic [19:0] i_raw_thermal_value,
   input  wire logic [15:0] i_raw_moisture_value,
   output logic             o_measure_start,
   output logic             o_measuring,
   output logic      [4:0]  o_thermal_samples,
   output logic      [4:0]  o_baro_samples,
   output logic      [4:0]  o_moisture_samples,
   output logic      [4:0]  o_filter_coeff,
   output logic             o_three_wire_select
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   for (genvar g = 0; g < 8; g++)
   begin : g_check
      if (STANDBY_CYCLES[g] == '0)
      begin : g_bad
         $error("Standby interval count must be at least one cycle");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoding of the oversampling fields (os_count) and of the filter field (filter_count)
   function automatic logic [4:0] os_count(input logic [2:0] code);
      case (code)
         3'h0:    os_count = 5'h00;
         3'h1:    os_count = 5'h01;
         3'h2:    os_count = 5'h02;
         3'h3:    os_count = 5'h04;
         3'h4:    os_count = 5'h08;
         default: os_count = env_meas_pkg::MAX_SAMPLES;
      endcase
   endfunction : os_count

   function automatic logic [4:0] filter_count(input logic [2:0] code);
      case (code)
         3'h0:    filter_count = 5'h00;
         3'h1:    filter_count = 5'h02;
         3'h2:    filter_count = 5'h04;
         3'h3:    filter_count = 5'h08;
         default: filter_count = env_meas_pkg::MAX_SAMPLES;
      endcase
   endfunction : filter_count

   function automatic logic is_forced(input logic [1:0] mode);
      is_forced = (mode != env_meas_pkg::MODE_SLEEP) && (mode != env_meas_pkg::MODE_NORMAL);
   endfunction : is_forced

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONVERT, SEQ_STANDBY} seq_state_t;

   seq_state_t                    state_r;
   env_meas_pkg::meas_control_t   meas_r;
   env_meas_pkg::rate_setup_t     setup_r;
   logic [2:0]                    moisture_os_r;
   logic [2:0]                    moisture_os_eff_r;
   logic [19:0]                   baro_r;
   logic [19:0]                   thermal_r;
   logic [15:0]                   moisture_r;
   logic [env_meas_pkg::STANDBY_W-1:0] standby_cnt_r;
   logic [7:0]                    rdata_nxt;
   logic                          wr_meas;
   logic                          wr_moisture;
   logic                          wr_setup;
   logic                          capture;
   logic                          forced_done;

   assign wr_meas     = i_reg_wr && (i_reg_addr == env_meas_pkg::ADDR_MEAS_CONTROL);
   assign wr_moisture = i_reg_wr && (i_reg_addr == env_meas_pkg::ADDR_MOISTURE_CONTROL);
   assign wr_setup    = i_reg_wr && (i_reg_addr == env_meas_pkg::ADDR_RATE_SETUP);
   assign capture     = (state_r == SEQ_CONVERT) && i_result_valid;
   assign forced_done = capture && is_forced(meas_r.mode);

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         meas_r <= env_meas_pkg::CONTROL_RESET;
      end
      else if (wr_meas)
      begin
         // A host write is newer than the forced-mode return to sleep
         meas_r <= i_reg_wdata;                                          // [R2] [R3] [R4]
      end
      else if (forced_done)
      begin
         meas_r.mode <= env_meas_pkg::MODE_SLEEP;                        // [R6]
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         moisture_os_r     <= env_meas_pkg::OS_SKIP;
         moisture_os_eff_r <= env_meas_pkg::OS_SKIP;
      end
      else
      begin
         if (wr_moisture)
         begin
            moisture_os_r <= i_reg_wdata[2:0];
         end
         if (wr_meas)
         begin
            // Staged copy only goes live with the measurement control write
            moisture_os_eff_r <= moisture_os_r;                          // [R1]
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         setup_r <= env_meas_pkg::CONTROL_RESET;
      end
      else if (wr_setup && (meas_r.mode != env_meas_pkg::MODE_NORMAL))   // [R7]
      begin
         setup_r        <= i_reg_wdata;                                  // [R8] [R9] [R10]
         setup_r.unused <= 1'b0;                                         // [R14]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Measurement sequencer
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         state_r         <= SEQ_IDLE;
         standby_cnt_r   <= '0;
         o_measure_start <= 1'b0;
      end
      else
      begin
         o_measure_start <= 1'b0;
         case (state_r)
            SEQ_IDLE:
            begin
               if (meas_r.mode != env_meas_pkg::MODE_SLEEP)              // [R6]
               begin
                  state_r         <= SEQ_CONVERT;
                  o_measure_start <= 1'b1;
               end
            end
            SEQ_CONVERT:
            begin
               if (i_result_valid)
               begin
                  if (meas_r.mode == env_meas_pkg::MODE_NORMAL)
                  begin
                     state_r       <= SEQ_STANDBY;
                     standby_cnt_r <= STANDBY_CYCLES[setup_r.standby_interval] - 1'b1; // [R8]
                  end
                  else
                  begin
                     state_r <= SEQ_IDLE;
                  end
               end
            end
            SEQ_STANDBY:
            begin
               if (meas_r.mode != env_meas_pkg::MODE_NORMAL)
               begin
                  // Leaving normal mode cancels the idle wait
                  state_r <= SEQ_IDLE;
               end
               else if (standby_cnt_r == '0)
               begin
                  state_r         <= SEQ_CONVERT;
                  o_measure_start <= 1'b1;
               end
               else
               begin
                  standby_cnt_r <= standby_cnt_r - 1'b1;
               end
            end
            default:
            begin
               state_r <= SEQ_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result capture, skipped channels forced to their marker value
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         baro_r     <= env_meas_pkg::SKIPPED_WIDE;
         thermal_r  <= env_meas_pkg::SKIPPED_WIDE;
         moisture_r <= env_meas_pkg::SKIPPED_MOISTURE;
      end
      else if (capture)
      begin
         baro_r     <= (meas_r.baro_os == env_meas_pkg::OS_SKIP) ?
                       env_meas_pkg::SKIPPED_WIDE : i_raw_baro_value;    // [R5]
         thermal_r  <= (meas_r.thermal_os == env_meas_pkg::OS_SKIP) ?
                       env_meas_pkg::SKIPPED_WIDE : i_raw_thermal_value; // [R5]
         moisture_r <= (moisture_os_eff_r == env_meas_pkg::OS_SKIP) ?
                       env_meas_pkg::SKIPPED_MOISTURE : i_raw_moisture_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded settings toward the converter and serial port
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_thermal_samples   <= '0;
         o_baro_samples      <= '0;
         o_moisture_samples  <= '0;
         o_filter_coeff      <= '0;
         o_three_wire_select <= 1'b0;
         o_measuring         <= 1'b0;
      end
      else
      begin
         o_thermal_samples   <= os_count(meas_r.thermal_os);             // [R5]
         o_baro_samples      <= os_count(meas_r.baro_os);                // [R5]
         o_moisture_samples  <= os_count(moisture_os_eff_r);             // [R1]
         o_filter_coeff      <= filter_count(setup_r.filter_coeff);      // [R9]
         o_three_wire_select <= setup_r.three_wire_select;               // [R10]
         o_measuring         <= (state_r == SEQ_CONVERT) && !i_result_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path; unmapped offsets read zero
   always_comb
   begin
      case (i_reg_addr)
         env_meas_pkg::ADDR_MOISTURE_CONTROL: rdata_nxt = {5'h00, moisture_os_r};
         env_meas_pkg::ADDR_MEAS_CONTROL:     rdata_nxt = meas_r;
         env_meas_pkg::ADDR_RATE_SETUP:       rdata_nxt = setup_r;
         env_meas_pkg::ADDR_BARO_HIGH:        rdata_nxt = baro_r[19:12];                        // [R11]
         env_meas_pkg::ADDR_BARO_MID:         rdata_nxt = baro_r[11:4];                         // [R11]
         env_meas_pkg::ADDR_BARO_LOW:         rdata_nxt = {baro_r[3:0], env_meas_pkg::LOW_NIBBLE_ZERO}; // [R11] [R14]
         env_meas_pkg::ADDR_THERMAL_HIGH:     rdata_nxt = thermal_r[19:12];                     // [R12]
         env_meas_pkg::ADDR_THERMAL_MID:      rdata_nxt = thermal_r[11:4];                      // [R12]
         env_meas_pkg::ADDR_THERMAL_LOW:      rdata_nxt = {thermal_r[3:0], env_meas_pkg::LOW_NIBBLE_ZERO}; // [R12] [R14]
         env_meas_pkg::ADDR_MOISTURE_HIGH:    rdata_nxt = moisture_r[15:8];                     // [R13]
         env_meas_pkg::ADDR_MOISTURE_LOW:     rdata_nxt = moisture_r[7:0];                      // [R13]
         default:                             rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_reg_rdata <= 8'h00;
      end
      else if (i_reg_rd)
      begin
         o_reg_rdata <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   a_moisture_staged: assert property (                                  // [R1]
      wr_moisture && !wr_meas ##1 !wr_meas |=> $stable(moisture_os_eff_r) && o_moisture_samples == $past(o_moisture_samples))
      else $error("Moisture oversampling changed without control write");

   a_moisture_apply: assert property (                                   // [R1]
      wr_meas |=> ##1 o_moisture_samples == os_count($past(moisture_os_r, 2)))
      else $error("Moisture oversampling not applied by control write");

   a_thermal_field: assert property (                                    // [R2]
      wr_meas ##1 !wr_meas ##1 (i_reg_rd && i_reg_addr == env_meas_pkg::ADDR_MEAS_CONTROL && !forced_done)
      |=> o_reg_rdata[7:5] == $past(i_reg_wdata[7:5], 3))
      else $error("Thermal oversampling not at bits 7:5");

   a_baro_field: assert property (                                       // [R3]
      wr_meas && i_reg_wdata[4:2] == 3'h0 |=> ##1 o_baro_samples == 5'h00)
      else $error("Barometric oversampling not at bits 4:2");

   a_mode_field: assert property (                                       // [R4]
      wr_meas && i_reg_wdata[1:0] == 2'h3 && state_r == SEQ_IDLE |=> ##1 o_measure_start)
      else $error("Normal mode write did not start a measurement");

   a_skip_marker: assert property (                                      // [R5]
      capture && meas_r.baro_os == env_meas_pkg::OS_SKIP |=> baro_r == 20'h80000)
      else $error("Skipped barometric result not forced to marker");

   a_max_samples: assert property (                                     // [R5]
      meas_r.thermal_os >= 3'h5 && $stable(meas_r) |=> o_thermal_samples == 5'h10)
      else $error("High thermal code did not select sixteen samples");

   a_forced_once: assert property (                                     // [R6]
      forced_done && !wr_meas |=> meas_r.mode == 2'h0 ##1 state_r == SEQ_IDLE ##1 !o_measure_start)
      else $error("Forced measurement did not return to sleep");

   a_setup_locked: assert property (                                    // [R7]
      wr_setup && meas_r.mode == 2'h3 |=> $stable(setup_r))
      else $error("Rate setup write accepted in normal mode");

   a_standby_load: assert property (                                    // [R8]
      capture && meas_r.mode == 2'h3 |=> state_r == SEQ_STANDBY
      && standby_cnt_r == STANDBY_CYCLES[$past(setup_r.standby_interval)] - 1'b1)
      else $error("Standby interval loaded with wrong count");

   a_filter_max: assert property (                                      // [R9]
      wr_setup && meas_r.mode == 2'h0 && i_reg_wdata[4:2] >= 3'h4 |=> ##1 o_filter_coeff == 5'h10)
      else $error("High filter code did not select sixteen");

   a_three_wire: assert property (                                      // [R10]
      wr_setup && meas_r.mode == 2'h0 |=> ##1 o_three_wire_select == $past(i_reg_wdata[0], 2))
      else $error("Three-wire select does not follow bit 0");

   a_baro_split: assert property (                                      // [R11]
      i_reg_rd && i_reg_addr == env_meas_pkg::ADDR_BARO_LOW |=> o_reg_rdata == {$past(baro_r[3:0]), 4'h0})
      else $error("Barometric low nibble misplaced");

   a_thermal_split: assert property (                                   // [R12]
      i_reg_rd && i_reg_addr == env_meas_pkg::ADDR_THERMAL_HIGH |=> o_reg_rdata == $past(thermal_r[19:12]))
      else $error("Thermal high byte misplaced");

   a_moisture_split: assert property (                                  // [R13]
      i_reg_rd && i_reg_addr == env_meas_pkg::ADDR_MOISTURE_LOW |=> o_reg_rdata == $past(moisture_r[7:0]))
      else $error("Moisture low byte misplaced");

   a_unused_zero: assert property (                                     // [R14]
      i_reg_rd && i_reg_addr == env_meas_pkg::ADDR_RATE_SETUP |=> o_reg_rdata[1] == 1'b0)
      else $error("Unused rate setup bit reads nonzero");

endmodule : env_sensor_measure_control_regs

// ==== env_meas_pkg.sv ====
// Constants and carriers for the measurement control and result registers.
// Assumes a 10 MHz device clock and a byte-wide register port.
package env_meas_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] ADDR_MOISTURE_CONTROL = 8'hF2;
   localparam logic [7:0] ADDR_MEAS_CONTROL     = 8'hF4;
   localparam logic [7:0] ADDR_RATE_SETUP       = 8'hF5;
   localparam logic [7:0] ADDR_BARO_HIGH        = 8'hF7;
   localparam logic [7:0] ADDR_BARO_MID         = 8'hF8;
   localparam logic [7:0] ADDR_BARO_LOW         = 8'hF9;
   localparam logic [7:0] ADDR_THERMAL_HIGH     = 8'hFA;
   localparam logic [7:0] ADDR_THERMAL_MID      = 8'hFB;
   localparam logic [7:0] ADDR_THERMAL_LOW      = 8'hFC;
   localparam logic [7:0] ADDR_MOISTURE_HIGH    = 8'hFD;
   localparam logic [7:0] ADDR_MOISTURE_LOW     = 8'hFE;

   ////////////////////////////////////////////////////////////////////////////
   // Field encodings and reset values
   localparam logic [1:0]  MODE_SLEEP        = 2'h0;
   localparam logic [1:0]  MODE_NORMAL       = 2'h3;
   localparam logic [2:0]  OS_SKIP           = 3'h0;
   localparam logic [19:0] SKIPPED_WIDE      = 20'h80000;
   localparam logic [15:0] SKIPPED_MOISTURE  = 16'h8000;
   localparam logic [7:0]  CONTROL_RESET     = 8'h00;
   localparam logic [3:0]  LOW_NIBBLE_ZERO   = 4'h0;
   localparam logic [4:0]  MAX_SAMPLES       = 5'h10;

   ////////////////////////////////////////////////////////////////////////////
   // Standby interval timing
   localparam int unsigned CLK_FREQ_HZ = 10_000_000;
   localparam int unsigned CYC_PER_US  = CLK_FREQ_HZ / 1_000_000;
   localparam int unsigned STANDBY_W   = 24;
   // Interval per code, index 0 first, in microseconds
   localparam int unsigned STBY_US_0 = 500;
   localparam int unsigned STBY_US_1 = 62_500;
   localparam int unsigned STBY_US_2 = 125_000;
   localparam int unsigned STBY_US_3 = 250_000;
   localparam int unsigned STBY_US_4 = 500_000;
   localparam int unsigned STBY_US_5 = 1_000_000;
   localparam int unsigned STBY_US_6 = 10_000;
   localparam int unsigned STBY_US_7 = 20_000;
   localparam logic [7:0][STANDBY_W-1:0] STANDBY_CYCLES_DEF = {
      STANDBY_W'(STBY_US_7 * CYC_PER_US), STANDBY_W'(STBY_US_6 * CYC_PER_US),
      STANDBY_W'(STBY_US_5 * CYC_PER_US), STANDBY_W'(STBY_US_4 * CYC_PER_US),
      STANDBY_W'(STBY_US_3 * CYC_PER_US), STANDBY_W'(STBY_US_2 * CYC_PER_US),
      STANDBY_W'(STBY_US_1 * CYC_PER_US), STANDBY_W'(STBY_US_0 * CYC_PER_US)};

   ////////////////////////////////////////////////////////////////////////////
   // Register layouts
   typedef struct packed {
      logic [2:0] thermal_os;
      logic [2:0] baro_os;
      logic [1:0] mode;
   } meas_control_t;

   typedef struct packed {
      logic [2:0] standby_interval;
      logic [2:0] filter_coeff;
      logic       unused;
      logic       three_wire_select;
   } rate_setup_t;

endpackage : env_meas_pkg

// ==== host_port_model.sv ====
// Host side of the register port: one byte write or read per strobe.
// Assumes one-cycle strobes taken on the rising edge and registered read data.
`timescale 1ns/1ns

module host_port_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic      [7:0] o_addr,
   output logic            o_wr,
   output logic      [7:0] o_wdata,
   output logic            o_rd
);
   initial
   begin
      o_addr = 8'h00;
      o_wr = 1'b0;
      o_wdata = 8'h00;
      o_rd = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Released lines show the inverse, so a stale value never looks valid
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clk);
      #1;
      d = i_rdata;
      o_rd = 1'b0;
      o_addr = ~a;
   endtask : read_reg
endmodule : host_port_model

// ==== env_sensor_measure_control_regs_test.sv ====
// Self-checking bench for the measurement control and result registers.
// Assumes host_port_model on the register port; the converter is driven here.
`timescale 1ns/1ns

module env_sensor_measure_control_regs_test;
   logic        i_clk = 1'b0;
   logic        i_reset = 1'b1;
   logic [7:0]  addr, wdata, rdata;
   logic        wr, rd, start, meas, tws;
   logic        valid = 1'b0;
   logic [19:0] rb = 20'h00000, rt = 20'h00000;
   logic [15:0] rm = 16'h0000, rnd = 16'hF781;
   logic [4:0]  ts, bs, ms, fc;
   int          fails = 0, checked = 0, cycles = 0;
   int          starts = 0, exp_starts = 0;
   int          meas_m, setup_m, hst_m, heff_m, baro_m, therm_m, moist_m;

   always #50 i_clk = ~i_clk;

   // Start pulses counted mid-cycle, away from the edge that launches them
   always @(negedge i_clk)
   begin
      if (start === 1'b1)
         starts++;
   end

   env_sensor_measure_control_regs #(.STANDBY_CYCLES({8{24'h000004}})) i_dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(addr), .i_reg_wr(wr),
      .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_result_valid(valid),
      .i_raw_baro_value(rb), .i_raw_thermal_value(rt), .i_raw_moisture_value(rm),
      .o_measure_start(start), .o_measuring(meas), .o_thermal_samples(ts),
      .o_baro_samples(bs), .o_moisture_samples(ms), .o_filter_coeff(fc),
      .o_three_wire_select(tws));

   host_port_model i_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
      .o_wdata(wdata), .o_rd(rd));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function automatic int smp(int c);
      return (c == 0) ? 0 : (c > 4) ? 16 : 1 << (c - 1);
   endfunction : smp

   function automatic int exp_rd(int a);
      case (a)
         'hF2: return hst_m;
         'hF4: return meas_m;
         'hF5: return setup_m;
         'hF7: return baro_m >> 12;
         'hF8: return (baro_m >> 4) & 'hFF;
         'hF9: return (baro_m & 'hF) << 4;
         'hFA: return therm_m >> 12;
         'hFB: return (therm_m >> 4) & 'hFF;
         'hFC: return (therm_m & 'hF) << 4;
         'hFD: return moist_m >> 8;
         'hFE: return moist_m & 'hFF;
         default: return 0;
      endcase
   endfunction : exp_rd

   task automatic check_byte(string n, logic [7:0] e, logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : check_byte

   task automatic check_cnt(string n, logic [4:0] e, logic [4:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : check_cnt

   task automatic rd_chk(logic [7:0] a);
      logic [7:0] d;
      i_host.read_reg(a, d);
      check_byte($sformatf("register %h", a), 8'(exp_rd(a)), d);
   endtask : rd_chk

   // Decoded outputs trail their register by one edge
   task automatic dec_chk();
      int f;
      @(posedge i_clk);
      #1;
      f = (setup_m >> 2) & 7;
      check_cnt("thermal samples", 5'(smp((meas_m >> 5) & 7)), ts);
      check_cnt("baro samples", 5'(smp((meas_m >> 2) & 7)), bs);
      check_cnt("moisture samples", 5'(smp(heff_m & 7)), ms);
      check_cnt("filter", 5'((f == 0) ? 0 : (f > 3) ? 16 : 1 << f), fc);
      check_cnt("three wire", 5'(setup_m & 1), {4'h0, tws});
   endtask : dec_chk

   task automatic convert();
      int n;
      n = 0;
      while (meas !== 1'b1 && n < 50)
      begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check_cnt("measuring", 5'h01, {4'h0, meas});
      exp_starts++;
      check_cnt("measure starts", 5'(exp_starts), 5'(starts));
      rnd = lfsr(rnd);
      rb = {rnd, rnd[3:0]};
      rnd = lfsr(rnd);
      rt = {rnd[3:0], rnd};
      rnd = lfsr(rnd);
      rm = rnd;
      valid = 1'b1;
      @(posedge i_clk);
      #1;
      valid = 1'b0;
      baro_m = (((meas_m >> 2) & 7) == 0) ? 'h80000 : int'(rb);
      therm_m = (((meas_m >> 5) & 7) == 0) ? 'h80000 : int'(rt);
      moist_m = ((heff_m & 7) == 0) ? 'h8000 : int'(rm);
      if ((meas_m & 3) != 3)
         meas_m = meas_m & 'hFC;
      check_cnt("measuring done", 5'h00, {4'h0, meas});
   endtask : convert

   task automatic tally_and_finish();
      $display("Comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   // Run is a few hundred cycles; the ceiling leaves wide margin
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         $display("[FAIL] timeout expected finish seen hang");
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [7:0] v;
      {meas_m, setup_m, hst_m, heff_m} = '0;
      baro_m = 'h80000;
      therm_m = 'h80000;
      moist_m = 'h8000;
      repeat (2) @(posedge i_clk);
      #1;
      i_reset = 1'b0;
      for (int a = 'hF0; a <= 'hFE; a++)
         rd_chk(8'(a));
      // Setup is written from sleep so it is always accepted
      for (int c = 0; c < 8; c++)
      begin
         rnd = lfsr(rnd);
         v = (rnd[7:0] & 8'hE3) | 8'(c << 2);
         setup_m = v & 'hFD;
         i_host.write_reg(env_meas_pkg::ADDR_RATE_SETUP, v);
         dec_chk();
         rd_chk(env_meas_pkg::ADDR_RATE_SETUP);
      end
      for (int c = 0; c < 8; c++)
      begin
         meas_m = (c << 5) | ((7 - c) << 2);
         heff_m = hst_m;
         i_host.write_reg(env_meas_pkg::ADDR_MEAS_CONTROL, 8'(meas_m));
         // Read back two cycles after the write, before the decoded check
         rd_chk(env_meas_pkg::ADDR_MEAS_CONTROL);
         dec_chk();
      end
      hst_m = 3;
      i_host.write_reg(env_meas_pkg::ADDR_MOISTURE_CONTROL, 8'h03);
      dec_chk();
      heff_m = hst_m;
      i_host.write_reg(env_meas_pkg::ADDR_MEAS_CONTROL, 8'(meas_m));
      dec_chk();
      // Forced: pressure skipped with mode 01, temperature skipped with mode 10
      for (int m = 1; m < 3; m++)
      begin
         meas_m = (m == 1) ? 'h21 : 'h16;
         i_host.write_reg(env_meas_pkg::ADDR_MEAS_CONTROL, 8'(meas_m));
         convert();
         for (int a = 'hF4; a <= 'hFE; a++)
            rd_chk(8'(a));
      end
      meas_m = 'h27;
      i_host.write_reg(env_meas_pkg::ADDR_MEAS_CONTROL, 8'h27);
      convert();
      i_host.write_reg(env_meas_pkg::ADDR_RATE_SETUP, 8'hFF);
      rd_chk(env_meas_pkg::ADDR_RATE_SETUP);
      convert();
      meas_m = 'h24;
      i_host.write_reg(env_meas_pkg::ADDR_MEAS_CONTROL, 8'h24);
      repeat (20) @(posedge i_clk);
      #1;
      check_cnt("measuring idle", 5'h00, {4'h0, meas});
      check_cnt("measure starts idle", 5'(exp_starts), 5'(starts));
      for (int a = 'hF7; a <= 'hFE; a++)
         rd_chk(8'(a));
      tally_and_finish();
   end
endmodule : env_sensor_measure_control_regs_test
